// ### rtl/gcf_pkg.sv
// register map, field layout and reset values of the graphics config header part
// assumes an apb slave whose registers each take one aligned 32-bit word
package gcf_pkg;

  // ----------------------------------------------------------------
  // bus widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_MMIO_BASE = 6'h14;
  localparam logic [5:0] IDX_SUBSYS_VENDOR = 6'h2c;
  localparam logic [5:0] IDX_SUBSYS = 6'h2e;
  localparam logic [5:0] IDX_ROM_BASE = 6'h30;
  localparam logic [5:0] IDX_CAP_HEAD = 6'h34;
  localparam logic [5:0] IDX_IRQ_LINE = 6'h3c;
  localparam logic [5:0] IDX_IRQ_PIN = 6'h3d;
  localparam logic [5:0] IDX_MIN_GNT = 6'h3e;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned MMIO_BASE_LSB = 19;
  localparam int unsigned MMIO_BASE_W = 13;
  localparam logic [31:0] MMIO_WR_MASK = 32'hfff80000;
  localparam logic [31:0] IRQ_LINE_WR_MASK = 32'h000000ff;

  // ----------------------------------------------------------------
  // reset and hardwired values
  // ----------------------------------------------------------------
  localparam logic [31:0] MMIO_BASE_RST = 32'h00000000;
  localparam logic [15:0] SUBSYS_RST = 16'h0000;
  localparam logic [31:0] ROM_BASE_VAL = 32'h00000000;
  localparam logic [7:0] CAP_HEAD_VAL = 8'hdc;
  localparam logic [31:0] IRQ_LINE_RST = 32'h00000000;
  localparam logic [7:0] IRQ_PIN_VAL = 8'h01;
  localparam logic [7:0] MIN_GNT_VAL = 8'h00;

  // ----------------------------------------------------------------
  // apb answer phase
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {PH_IDLE, PH_ANSWER} gcf_phase_t;

endpackage

// ### rtl/gcf_byte_reg.sv
// byte-enabled register with a per-bit writable mask
// assumes wr_en is a one-cycle pulse from the apb access edge
`timescale 1ns/1ns
module gcf_byte_reg
#(
  parameter logic [31:0] WR_MASK = 32'hffffffff,
  parameter logic [31:0] RST_VAL = 32'h00000000
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write port
  input wire logic wr_en,
  input wire logic [3:0] wr_strb,
  input wire logic [31:0] wr_data,
  // stored value
  output logic [31:0] value
);

  typedef struct packed
  {
    logic [31:0] val;
  } gcf_breg_t;

  gcf_breg_t st_ff;
  gcf_breg_t nxt_st;

  // merge enabled bytes, writable bits only
  always_comb
  begin
    nxt_st = st_ff;
    for (int b = 0; b < 4; b++)
    begin
      if (wr_en && wr_strb[b])
      begin
        nxt_st.val[b*8 +: 8] = (wr_data[b*8 +: 8] & WR_MASK[b*8 +: 8]) |
                               (st_ff.val[b*8 +: 8] & ~WR_MASK[b*8 +: 8]);
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '{val: RST_VAL};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign value = st_ff.val;

endmodule

// ### rtl/gcf_wonce_reg.sv
// 16-bit write-once register, cleared only by reset
// assumes wr_en is a one-cycle pulse from the apb access edge
`timescale 1ns/1ns
module gcf_wonce_reg
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write port
  input wire logic wr_en,
  input wire logic [1:0] wr_strb,
  input wire logic [15:0] wr_data,
  // stored value and lock
  output logic [15:0] value,
  output logic locked
);

  typedef struct packed
  {
    logic [15:0] val;
    logic lock;
  } gcf_wonce_t;

  gcf_wonce_t st_ff;
  gcf_wonce_t nxt_st;

  // first write takes enabled bytes and locks
  always_comb
  begin
    nxt_st = st_ff;
    if (wr_en && !st_ff.lock)
    begin
      for (int b = 0; b < 2; b++)
      begin
        if (wr_strb[b])
        begin
          nxt_st.val[b*8 +: 8] = wr_data[b*8 +: 8];
        end
      end
      nxt_st.lock = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '{val: gcf_pkg::SUBSYS_RST, lock: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign value = st_ff.val;
  assign locked = st_ff.lock;

endmodule

// ### rtl/gcf_cfg_regs.sv
// apb register bank for the graphics function's config header part
// assumes an apb master on pclk and a memory address stream on pclk
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
module gcf_cfg_regs
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gcf_pkg::ADDR_W-1:0] paddr,
  input wire logic [gcf_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [gcf_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory address decode
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  output logic mmio_hit,
  // configured values
  output logic [gcf_pkg::MMIO_BASE_W-1:0] mmio_base,
  output logic [7:0] irq_line,
  output logic [15:0] subsys_vendor,
  output logic [15:0] subsys_id,
  output logic subsys_locked
);

  // ----------------------------------------------------------------
  // byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_MMIO = {gcf_pkg::IDX_MMIO_BASE, 2'b00};
  localparam logic [7:0] ADR_SVEND = {gcf_pkg::IDX_SUBSYS_VENDOR, 2'b00};
  localparam logic [7:0] ADR_SUBSYS = {gcf_pkg::IDX_SUBSYS, 2'b00};
  localparam logic [7:0] ADR_ROM = {gcf_pkg::IDX_ROM_BASE, 2'b00};
  localparam logic [7:0] ADR_CAP = {gcf_pkg::IDX_CAP_HEAD, 2'b00};
  localparam logic [7:0] ADR_IRQL = {gcf_pkg::IDX_IRQ_LINE, 2'b00};
  localparam logic [7:0] ADR_IRQP = {gcf_pkg::IDX_IRQ_PIN, 2'b00};
  localparam logic [7:0] ADR_MGNT = {gcf_pkg::IDX_MIN_GNT, 2'b00};

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    gcf_pkg::gcf_phase_t phase;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic hit;
    logic [12:0] base;
    logic [7:0] line;
    logic [15:0] svend;
    logic [15:0] subsystem_code;
    logic lock;
  } gcf_state_t;

  gcf_state_t st_ff;
  gcf_state_t nxt_st;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic setup;
  logic access_done;
  logic wr_done;
  logic mapped;
  logic sel_mmio;
  logic sel_svend;
  logic sel_subsys;
  logic sel_irql;
  logic [31:0] mmio_val;
  logic [31:0] irql_val;
  logic [15:0] svend_val;
  logic [15:0] sid_val;
  logic svend_lock;
  logic sid_lock;
  logic [31:0] rd_mux;
  logic [31:0] rd_word;
  logic wr_mmio;
  logic wr_irql;
  logic wr_svend;
  logic wr_subsys;
  logic win_match;
  logic [31:0] rd_mmio;
  logic [31:0] rd_svend;
  logic [31:0] rd_subsys;
  logic [31:0] rd_rom;
  logic [31:0] rd_cap;
  logic [31:0] rd_irql;
  logic [31:0] rd_irqp;
  logic [31:0] rd_mgnt;

  // apb phases
  assign setup = psel && !penable;
  assign access_done = psel && penable && st_ff.ready;
  assign wr_done = access_done && pwrite;

  // register selects
  assign sel_mmio = (paddr == ADR_MMIO);
  assign sel_svend = (paddr == ADR_SVEND);
  assign sel_subsys = (paddr == ADR_SUBSYS);
  assign sel_irql = (paddr == ADR_IRQL);

  // ----------------------------------------------------------------
  // write strobes and window match
  // ----------------------------------------------------------------

  // one pulse per register at the completing access edge
  assign wr_mmio = wr_done && sel_mmio;
  assign wr_irql = wr_done && sel_irql;
  assign wr_svend = wr_done && sel_svend;
  assign wr_subsys = wr_done && sel_subsys;

  // memory address against the mirrored base
  assign win_match = (mem_addr[31:gcf_pkg::MMIO_BASE_LSB] == st_ff.base);

  // mapped addresses, read-only ones included
  always_comb
  begin
    case (paddr)
      ADR_MMIO, ADR_SVEND, ADR_SUBSYS, ADR_ROM,
      ADR_CAP, ADR_IRQL, ADR_IRQP, ADR_MGNT:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------

  // mmio base: only bits 31:19 take a write
  gcf_byte_reg
  #(
    .WR_MASK(gcf_pkg::MMIO_WR_MASK),
    .RST_VAL(gcf_pkg::MMIO_BASE_RST)
  )
  u_mmio
  (
    .clk(pclk),
    .rst_n(presetn),
    .wr_en(wr_mmio),
    .wr_strb(pstrb),
    .wr_data(pwdata),
    .value(mmio_val)
  );

  // irq routing line: low byte only
  gcf_byte_reg
  #(
    .WR_MASK(gcf_pkg::IRQ_LINE_WR_MASK),
    .RST_VAL(gcf_pkg::IRQ_LINE_RST)
  )
  u_irql
  (
    .clk(pclk),
    .rst_n(presetn),
    .wr_en(wr_irql),
    .wr_strb(pstrb),
    .wr_data(pwdata),
    .value(irql_val)
  );

  // subsystem vendor code, write once
  gcf_wonce_reg u_svend
  (
    .clk(pclk),
    .rst_n(presetn),
    .wr_en(wr_svend),
    .wr_strb(pstrb[1:0]),
    .wr_data(pwdata[15:0]),
    .value(svend_val),
    .locked(svend_lock)
  );

  // subsystem code, write once
  gcf_wonce_reg u_subsys
  (
    .clk(pclk),
    .rst_n(presetn),
    .wr_en(wr_subsys),
    .wr_strb(pstrb[1:0]),
    .wr_data(pwdata[15:0]),
    .value(sid_val),
    .locked(sid_lock)
  );

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------

  // mmio base: window bits kept, mask, prefetch, type and space bits zero
  assign rd_mmio = {mmio_val[31:gcf_pkg::MMIO_BASE_LSB],
                    19'h00000};

  // write-once codes and irq line sit in the low bits
  assign rd_svend = {16'h0000, svend_val};
  assign rd_subsys = {16'h0000, sid_val};
  assign rd_irql = {24'h000000, irql_val[7:0]};

  // hardwired registers, writes never reach them
  assign rd_rom = gcf_pkg::ROM_BASE_VAL;
  assign rd_cap = {24'h000000, gcf_pkg::CAP_HEAD_VAL};
  assign rd_irqp = {24'h000000, gcf_pkg::IRQ_PIN_VAL};
  assign rd_mgnt = {24'h000000, gcf_pkg::MIN_GNT_VAL};

  // ----------------------------------------------------------------
  // read select
  // ----------------------------------------------------------------

  // read value per register; unmapped places read zero
  always_comb
  begin
    case (paddr)
      ADR_MMIO:
        rd_mux = rd_mmio;
      ADR_SVEND:
        rd_mux = rd_svend;
      ADR_SUBSYS:
        rd_mux = rd_subsys;
      ADR_ROM:
        rd_mux = rd_rom;
      ADR_CAP:
        rd_mux = rd_cap;
      ADR_IRQL:
        rd_mux = rd_irql;
      ADR_IRQP:
        rd_mux = rd_irqp;
      ADR_MGNT:
        rd_mux = rd_mgnt;
      default:
        rd_mux = 32'h00000000;
    endcase
  end

  // writes put zero on the read bus
  assign rd_word = pwrite ? 32'h00000000 : rd_mux;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------

  // apb answer, mirrors of stored values, window match
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.ready = 1'b0;
    case (st_ff.phase)
      gcf_pkg::PH_IDLE:
      begin
        if (setup)
        begin
          // answer ready in the first access cycle
          nxt_st.phase = gcf_pkg::PH_ANSWER;
          nxt_st.ready = 1'b1;
          nxt_st.rdata = rd_word;
          // read-only targets still complete without error
          nxt_st.slverr = !mapped;
        end
      end
      gcf_pkg::PH_ANSWER:
      begin
        if (access_done)
        begin
          nxt_st.phase = gcf_pkg::PH_IDLE;
          nxt_st.rdata = 32'h00000000;
          nxt_st.slverr = 1'b0;
        end
        else
        begin
          nxt_st.ready = st_ff.ready;
        end
      end
      default:
      begin
        nxt_st.phase = gcf_pkg::PH_IDLE;
      end
    endcase
    // decode of the register window against memory cycles
    nxt_st.hit = mem_valid && win_match;
    nxt_st.base = mmio_val[31:gcf_pkg::MMIO_BASE_LSB];
    nxt_st.line = irql_val[7:0];
    nxt_st.svend = svend_val;
    nxt_st.subsystem_code = sid_val;
    nxt_st.lock = svend_lock && sid_lock;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '{
        phase: gcf_pkg::PH_IDLE,
        rdata: 32'h00000000,
        ready: 1'b0,
        slverr: 1'b0,
        hit: 1'b0,
        base: gcf_pkg::MMIO_BASE_RST[31:gcf_pkg::MMIO_BASE_LSB],
        line: gcf_pkg::IRQ_LINE_RST[7:0],
        svend: gcf_pkg::SUBSYS_RST,
        subsystem_code: gcf_pkg::SUBSYS_RST,
        lock: 1'b0
      };
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = st_ff.rdata;
  assign pready = st_ff.ready;
  assign pslverr = st_ff.slverr;
  assign mmio_hit = st_ff.hit;
  assign mmio_base = st_ff.base;
  assign irq_line = st_ff.line;
  assign subsys_vendor = st_ff.svend;
  assign subsys_id = st_ff.subsystem_code;
  assign subsys_locked = st_ff.lock;

endmodule

// ### tb/gcf_cfg_regs_props.sv
// assertions on the ports of the config header register bank
// assumes a bind onto gcf_cfg_regs, one pclk domain
`timescale 1ns/1ns
module gcf_cfg_regs_props
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // decode and mirrors
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic mmio_hit,
  input wire logic [12:0] mmio_base,
  input wire logic [7:0] irq_line,
  input wire logic [15:0] subsys_vendor,
  input wire logic [15:0] subsys_id,
  input wire logic subsys_locked
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // answer phases of reads and low-byte writes
  sequence s_rd(logic [7:0] a);
    pready && !pwrite && paddr == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    pready && pwrite && paddr == a && pstrb[0];
  endsequence

  property p_setup;
    psel && !penable |=> pready;
  endproperty
  a_setup: assert property (p_setup)
    else $error("no ready after setup");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("ready stands too long");
  property p_cap;
    s_rd(8'hd0) |-> prdata == 32'hdc;
  endproperty
  a_cap: assert property (p_cap)
    else $error("bad capability head");
  property p_pin;
    s_rd(8'hf4) |-> prdata == 32'h1;
  endproperty
  a_pin: assert property (p_pin)
    else $error("bad irq pin");
  property p_rom;
    s_rd(8'hc0) |-> prdata == 32'h0;
  endproperty
  a_rom: assert property (p_rom)
    else $error("rom base not zero");
  property p_mmlow;
    s_rd(8'h50) |-> prdata[18:0] == 19'h0;
  endproperty
  a_mmlow: assert property (p_mmlow)
    else $error("mmio base low bits set");
  property p_err;
    pready && (paddr == 8'hc0 || paddr == 8'hd0) |-> !pslverr;
  endproperty
  a_err: assert property (p_err)
    else $error("error on read-only place");
  property p_irq;
    s_wr(8'hf0) |-> ##2 irq_line == $past(pwdata[7:0], 2);
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq line not stored");
  property p_hit;
    mem_valid && $stable(mmio_base) |=>
      mmio_hit == ($past(mem_addr[31:19]) == $past(mmio_base));
  endproperty
  a_hit: assert property (p_hit)
    else $error("window decode wrong");
  property p_wonce;
    subsys_locked && $past(subsys_locked) |-> $stable(subsys_vendor) && $stable(subsys_id);
  endproperty
  a_wonce: assert property (p_wonce)
    else $error("locked code changed");
endmodule

// ### tb/gcf_host_model.sv
// apb configuration master standing in for host firmware
// assumes pclk shared with the register bank
`timescale 1ns/1ns
module gcf_host_model
(
  // clock
  input wire logic pclk,
  // apb request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // wait limit ran out
  output logic hung
);
  // idle bus at time zero
  initial
  begin
    {psel, penable, pwrite, hung} = 4'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end

  // one transfer, held until ready is seen at an edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    hung = (pready !== 1'b1);
    q = prdata;
    e = pslverr;
  endtask

  // release the bus; stale address and data lines are inverted
  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~paddr;
    pwdata <= ~pwdata;
    @(posedge pclk);
  endtask
endmodule

// ### tb/test_gcf_cfg_regs.sv
// self-checking bench of the config header register bank
// assumes gcf_host_model as apb master and the props checker bound below
`timescale 1ns/1ns
module test_gcf_cfg_regs;
  logic pclk, presetn, mem_valid, psel, penable, pwrite, pready, pslverr, e;
  logic mmio_hit, subsys_locked;
  logic [31:0] mem_addr, pwdata, prdata, q;
  logic [7:0] paddr, irq_line;
  logic [3:0] pstrb;
  logic [12:0] mmio_base;
  logic [15:0] subsys_vendor, subsys_id;
  int fail_count = 0;
  int checks = 0;
  // read places with values after reset and after the write table
  logic [7:0] ra[9] = '{8'h50, 8'hb0, 8'hb8, 8'hc0, 8'hd0, 8'hf0, 8'hf4, 8'hf8, 8'h00};
  logic [31:0] rv[9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hdc, 32'h0, 32'h1, 32'h0, 32'h0};
  logic [31:0] wv[9] = '{32'hff000000, 32'h34, 32'habcd, 32'h0, 32'hdc, 32'hff, 32'h1,
    32'h0, 32'h0};
  // write table: address, data, strobes
  logic [7:0] wa[13] = '{8'hb0, 8'hb0, 8'hb8, 8'hb8, 8'h50, 8'h50, 8'hc0, 8'hd0, 8'hf0,
    8'hf0, 8'hf4, 8'hf8, 8'h00};
  logic [31:0] wd[13] = '{32'h1234, 32'hffff, 32'habcd, 32'h0, 32'hffffffff, 32'h0,
    32'hffffffff, 32'hff, 32'hff, 32'h12, 32'hff, 32'hff, 32'hff};
  logic [3:0] ws[13] = '{4'h1, 4'hf, 4'hf, 4'hf, 4'hf, 4'h7, 4'hf, 4'hf, 4'hf, 4'he, 4'hf,
    4'hf, 4'hf};
  // memory addresses at and beyond the window edges
  logic [31:0] ma[4] = '{32'hff000000, 32'hff07fffc, 32'hff080000, 32'hfef80000};

  gcf_cfg_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_valid(mem_valid), .mem_addr(mem_addr),
    .mmio_hit(mmio_hit), .mmio_base(mmio_base), .irq_line(irq_line),
    .subsys_vendor(subsys_vendor), .subsys_id(subsys_id), .subsys_locked(subsys_locked));
  gcf_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hung());

  // verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // compare one value
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb access; a hung bus ends the run
  task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d,
    input logic [3:0] s);
    u_host.xfer(a, w, d, s, q, e);
    if (u_host.hung)
    begin
      fail_count++;
      $display("wrong value at %0t: no ready", $time);
      results();
    end
  endtask

  // back-to-back reads of every place
  task automatic read_all(input logic [31:0] ev[9]);
    for (int i = 0; i < 9; i++)
    begin
      acc(ra[i], 1'b0, 32'h0, 4'h0);
      cmp(q, ev[i]);
      cmp(32'(e), 32'(ra[i] == 8'h00));
    end
    u_host.idle();
  endtask

  // 20 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial
  begin
    presetn = 1'b0;
    mem_valid = 1'b0;
    mem_addr = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    read_all(rv);
    $display("reset values done");
    // boot writes: codes first, then every place, back to back
    for (int i = 0; i < 13; i++)
    begin
      acc(wa[i], 1'b1, wd[i], ws[i]);
      cmp(32'(e), 32'(wa[i] == 8'h00));
    end
    u_host.idle();
    read_all(wv);
    @(negedge pclk);
    cmp(32'(mmio_base), 32'h1fe0);
    cmp(32'(irq_line), 32'hff);
    cmp({subsys_vendor, subsys_id}, 32'h0034abcd);
    cmp(32'(subsys_locked), 32'h1);
    @(posedge pclk);
    $display("write tests done");
    // window decode on both sides of its edges
    for (int i = 0; i < 4; i++)
    begin
      mem_valid <= 1'b1;
      mem_addr <= ma[i];
      @(posedge pclk);
      mem_valid <= 1'b0;
      @(negedge pclk);
      cmp(32'(mmio_hit), 32'(i < 2));
      @(posedge pclk);
    end
    $display("window decode done");
    // second reset unlocks the codes
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    read_all(rv);
    acc(8'hb8, 1'b1, 32'h5678, 4'h3);
    acc(8'hb8, 1'b0, 32'h0, 4'h0);
    cmp(q, 32'h5678);
    u_host.idle();
    $display("second reset done");
    results();
  end
endmodule

bind gcf_cfg_regs gcf_cfg_regs_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_valid(mem_valid),
  .mem_addr(mem_addr), .mmio_hit(mmio_hit), .mmio_base(mmio_base), .irq_line(irq_line),
  .subsys_vendor(subsys_vendor), .subsys_id(subsys_id), .subsys_locked(subsys_locked));
